// ===== logic/roc_curve.sv
// Inverse-time operate time calculator, one cycle of latency.
// Assumes the ratio is already capped and at least one in Q8.
`timescale 1ns/10ps
module roc_curve (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  roc_curve_if.calc cb
);

  typedef struct packed {
    logic [31:0] op_ms;
  } roc_curve_regs_t;

  roc_curve_regs_t r;
  roc_curve_regs_t next_r;
  logic [3:0] msb;
  logic [3:0] idx;
  logic [12:0] norm;
  logic [15:0] log2_q8;
  logic [47:0] f_q16;
  logic [47:0] t_us;
  logic [63:0] t_ms;

  // ----------------------------------------------------------------
  // Operate time t = TMS * (k / (ratio^alpha - 1) + c)
  // ----------------------------------------------------------------
  always_comb
  begin
    next_r = r;
    msb = 4'h8;
    for (int i = 9; i < 13; i++)
    begin
      if (cb.ratio_q8[i])
        msb = 4'(i);
    end
    norm = 13'(cb.ratio_q8 << (4'hc - msb));
    log2_q8 = {4'h0, 4'(msb - 4'h8), norm[11:4]};
    idx = 4'(cb.curve - roc_pkg::MODE_IEC_NI);
    if (idx > 4'ha)
      idx = 4'h0;
    case (roc_pkg::CURVE_ALPHA[idx])
      roc_pkg::ALPHA_ONE: f_q16 = 48'(cb.ratio_q8 - roc_pkg::RATIO_ONE) << 8;
      roc_pkg::ALPHA_TWO: f_q16 = 48'(cb.ratio_q8) * 48'(cb.ratio_q8) - 48'h10000;
      default: f_q16 = (48'(log2_q8) * roc_pkg::LN2_X_002_Q8) >> 8;
    endcase
    // Just at pickup the curve is infinite; keep the divisor nonzero
    if (cb.ratio_q8 <= roc_pkg::RATIO_ONE || f_q16 == 48'h0)
      f_q16 = 48'h1;
    t_us = ((48'(roc_pkg::CURVE_K_US[idx]) << 16) / f_q16)
      + 48'(roc_pkg::CURVE_C_US[idx]);
    t_ms = (64'(t_us) * 64'(cb.mult)) / roc_pkg::MULT_US_DIV;
    if (t_ms > 64'h00000000ffffffff)
      next_r.op_ms = 32'hffffffff;
    else
      next_r.op_ms = t_ms[31:0];
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      r <= '0;
    else
      r <= next_r;
  end

  assign cb.op_ms = r.op_ms;

endmodule

// ===== logic/roc_curve_if.sv
// Carries the operating point into the curve calculator and the time back.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface roc_curve_if;
  logic [12:0] ratio_q8;
  roc_pkg::roc_mode_t curve;
  logic [10:0] mult;
  logic [31:0] op_ms;
  modport calc (input ratio_q8, input curve, input mult, output op_ms);
  modport user (output ratio_q8, output curve, output mult, input op_ms);
endinterface

// ===== logic/roc_pkg.sv
// Shared constants and types for the residual overcurrent trip block.
// Assumes a 100 MHz system clock and a word-wide register port.
package roc_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_NS = 10;
  localparam int unsigned MS_NS = 1000000;
  localparam int unsigned TICK_CYCLES = MS_NS / CLK_NS;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [5:0] ADDR_MODE = 6'h00;
  localparam logic [5:0] ADDR_PICKUP = 6'h04;
  localparam logic [5:0] ADDR_MULT = 6'h08;
  localparam logic [5:0] ADDR_MIN_DLY = 6'h0c;
  localparam logic [5:0] ADDR_DEF_DLY = 6'h10;
  localparam logic [5:0] ADDR_RST_DLY = 6'h14;
  localparam logic [5:0] ADDR_STATUS = 6'h18;
  localparam logic [5:0] ADDR_IRQ_STAT = 6'h1c;
  localparam logic [5:0] ADDR_IRQ_MASK = 6'h20;
  localparam logic [5:0] ADDR_OP_TIME = 6'h24;
  localparam logic [5:0] ADDR_ELAPSED = 6'h28;

  // ----------------------------------------------------------------
  // Field positions, reset values and ranges
  // ----------------------------------------------------------------
  localparam int unsigned MODE_SENS_BIT = 4;
  localparam int unsigned IRQ_START_BIT = 0;
  localparam int unsigned IRQ_TRIP_BIT = 1;
  localparam logic [9:0] PICKUP_RST = 10'h032;
  localparam logic [15:0] PICKUP_MIN = 16'h000a;
  localparam logic [15:0] PICKUP_MIN_SENS = 16'h0005;
  localparam logic [15:0] PICKUP_MAX = 16'h03e8;
  localparam logic [10:0] MULT_RST = 11'h064;
  localparam logic [15:0] MULT_MIN = 16'h0005;
  localparam logic [15:0] MULT_MAX = 16'h05dc;
  localparam logic [15:0] DLY_RST = 16'h0064;
  localparam logic [15:0] DLY_MIN = 16'h0028;
  localparam logic [15:0] RST_DLY_MIN = 16'h003c;
  localparam logic [15:0] DLY_MAX = 16'hea60;
  localparam logic [12:0] RATIO_ONE = 13'h0100;
  localparam logic [12:0] RATIO_CAP = 13'h1400;

  // ----------------------------------------------------------------
  // Modes and curve constants (k and c in microseconds)
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    MODE_OFF = 4'b0000, MODE_DEF = 4'b0001, MODE_IEC_NI = 4'b0010,
    MODE_IEC_VI = 4'b0011, MODE_IEC_EI = 4'b0100, MODE_IEC_LI = 4'b0101,
    MODE_ANSI_I = 4'b0110, MODE_ANSI_MI = 4'b0111, MODE_ANSI_VI = 4'b1000,
    MODE_ANSI_EI = 4'b1001, MODE_ANSI_LI = 4'b1010, MODE_ANSI_LVI = 4'b1011,
    MODE_ANSI_LEI = 4'b1100
  } roc_mode_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_RUN = 2'b01, ST_TRIP = 2'b10, ST_HOLD = 2'b11
  } roc_state_t;

  localparam logic [1:0] ALPHA_SMALL = 2'h0;
  localparam logic [1:0] ALPHA_ONE = 2'h1;
  localparam logic [1:0] ALPHA_TWO = 2'h2;
  localparam logic [47:0] LN2_X_002_Q8 = 48'h38d;
  localparam logic [63:0] MULT_US_DIV = 64'h186a0;

  localparam logic [31:0] CURVE_K_US [0:10] = '{
    32'h000222e0, 32'h00cdfe60, 32'h04c4b400, 32'h07270e00, 32'h00002198,
    32'h0000c92c, 32'h012b3990, 32'h01ae4c40, 32'h00014ff0, 32'h01b3a370,
    32'h03d1a170};
  localparam logic [31:0] CURVE_C_US [0:10] = '{
    32'h0, 32'h0, 32'h0, 32'h0, 32'h00004844, 32'h0001bd50, 32'h00077df8,
    32'h0001db64, 32'h0002d2a8, 32'h000add40, 32'h0003d090};
  localparam logic [1:0] CURVE_ALPHA [0:10] = '{
    2'h0, 2'h1, 2'h2, 2'h1, 2'h0, 2'h0, 2'h2, 2'h2, 2'h0, 2'h2, 2'h2};

endpackage

// ===== logic/roc_trip_top.sv
// Residual overcurrent protection: pickup, definite and inverse timing,
// decision stage, blocking, settings registers and interrupt.
// Assumes the RMS input is on ref_clk_i, in 0.1 % of nominal current,
// and the blocking input may come from any clock domain.
//
// Summary of operation
// - Pickup and timing both work on the fundamental RMS of the residual current.
// - The mode selects off, definite time or one of eleven inverse curves, off at reset.
// - Pickup is set in whole percent of nominal, 10 to 1000 (5 when sensitive), default 50.
// - Inverse times are scaled by a multiplier of 0.05 to 15 in 0.01 steps, default 1.0.
// - Inverse curves have a minimum delay of 40 to 60000 ms, default 100 ms.
// - Definite time trips after a delay of 40 to 60000 ms, default 100 ms.
// - Curves that reset after a fixed time use a reset delay of 60 to 60000 ms, default 100.
// - Start is raised above pickup, trip once the selected delay has fully run.
// - General start and general trip follow the internal start and trip.
// - The blocking input disables the function and holds start and trip low.
// - An inverse trip needs both the curve delay and the minimum delay to expire.
// - Above twenty times pickup the inverse time stays at its twenty-times value.
// - Inverse time is multiplier times k over ratio to the alpha minus one, plus c.
// - Above 1.1 times pickup the inverse characteristic always operates.
//
// The strobed register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
module roc_trip_top #(
  parameter int unsigned TICK_CYCLES = roc_pkg::TICK_CYCLES
) (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic [5:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  input wire logic [15:0] residual_fundamental_rms_i,
  input wire logic rms_valid_i,
  input wire logic function_block_in_i,
  output logic internal_start_flag_o,
  output logic internal_trip_flag_o,
  output logic general_start_out_o,
  output logic general_trip_out_o,
  output logic irq_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    roc_pkg::roc_mode_t mode;
    logic sens;
    logic [9:0] pickup;
    logic [10:0] mult;
    logic [15:0] min_dly;
    logic [15:0] def_dly;
    logic [15:0] rst_dly;
    logic [1:0] irq_mask;
    logic [1:0] irq_stat;
    logic [15:0] rms;
    logic [2:0] blk_sync;
    logic blocked;
    logic [16:0] tick_cnt;
    logic tick;
    roc_pkg::roc_state_t state;
    logic [31:0] elapsed;
    logic [15:0] rcnt;
    logic start;
    logic trip;
    logic gen_start;
    logic gen_trip;
    logic [31:0] rdata;
  } roc_regs_t;

  localparam roc_regs_t REGS_RST = '{
    mode: roc_pkg::MODE_OFF,
    pickup: roc_pkg::PICKUP_RST,
    mult: roc_pkg::MULT_RST,
    min_dly: roc_pkg::DLY_RST,
    def_dly: roc_pkg::DLY_RST,
    rst_dly: roc_pkg::DLY_RST,
    state: roc_pkg::ST_IDLE,
    default: '0
  };

  localparam logic [16:0] TICK_LAST = 17'(TICK_CYCLES - 1);

  roc_regs_t r;
  roc_regs_t next_r;
  logic rst_meta;
  logic rst_n;
  logic [13:0] pk_lvl;
  logic above;
  logic drop;
  logic inverse;
  logic [23:0] ratio_full;
  logic [12:0] ratio_q8;
  logic [31:0] need_ms;
  logic [1:0] events;
  logic wr_hit;
  logic rd_hit;

  roc_curve_if cif ();

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ----------------------------------------------------------------
  // Setting clamp helper
  // ----------------------------------------------------------------
  function automatic logic [15:0] clamp16(
    input logic [31:0] v,
    input logic [15:0] lo,
    input logic [15:0] hi
  );
    logic [15:0] res;
    if (v < {16'h0, lo})
      res = lo;
    else if (v > {16'h0, hi})
      res = hi;
    else
      res = v[15:0];
    return res;
  endfunction

  // ----------------------------------------------------------------
  // Measurement comparison
  // ----------------------------------------------------------------
  always_comb
  begin
    pk_lvl = 14'({r.pickup, 3'b000}) + 14'({r.pickup, 1'b0});
    above = r.rms > {2'b00, pk_lvl};
    // Drop out at 95 % of pickup so a level near the setting cannot chatter
    drop = (21'(r.rms) * 21'h14) < (21'(pk_lvl) * 21'h13);
    inverse = r.mode >= roc_pkg::MODE_IEC_NI;
    if (pk_lvl == 14'h0)
      ratio_full = 24'hffffff;
    else
      ratio_full = {r.rms, 8'h00} / 24'(pk_lvl);
    if (ratio_full > 24'(roc_pkg::RATIO_CAP))
      ratio_q8 = roc_pkg::RATIO_CAP;
    else if (ratio_full < 24'(roc_pkg::RATIO_ONE))
      ratio_q8 = roc_pkg::RATIO_ONE;
    else
      ratio_q8 = ratio_full[12:0];
    if (inverse)
    begin
      if (cif.op_ms > 32'(r.min_dly))
        need_ms = cif.op_ms;
      else
        need_ms = 32'(r.min_dly);
    end
    else
      need_ms = 32'(r.def_dly);
  end

  assign cif.ratio_q8 = ratio_q8;
  assign cif.curve = r.mode;
  assign cif.mult = r.mult;

  roc_curve u_curve (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n),
    .cb(cif.calc)
  );

  assign wr_hit = reg_wr_i;
  assign rd_hit = reg_rd_i;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_r = r;
    next_r.tick = 1'b0;
    next_r.rdata = 32'h0;

    // Millisecond tick
    if (r.tick_cnt >= TICK_LAST)
    begin
      next_r.tick_cnt = 17'h0;
      next_r.tick = 1'b1;
    end
    else
      next_r.tick_cnt = r.tick_cnt + 17'h1;

    // Blocking input, accepted once two stages agree
    next_r.blk_sync = {r.blk_sync[1:0], function_block_in_i};
    if (r.blk_sync[2] == r.blk_sync[1])
      next_r.blocked = r.blk_sync[2];

    if (rms_valid_i)
      next_r.rms = residual_fundamental_rms_i;

    // Protection sequence
    if (r.mode == roc_pkg::MODE_OFF || r.blocked)
    begin
      next_r.state = roc_pkg::ST_IDLE;
      next_r.elapsed = 32'h0;
      next_r.rcnt = 16'h0;
      next_r.start = 1'b0;
      next_r.trip = 1'b0;
    end
    else
    begin
      case (r.state)
        roc_pkg::ST_IDLE:
        begin
          next_r.start = 1'b0;
          next_r.trip = 1'b0;
          next_r.elapsed = 32'h0;
          if (above)
          begin
            next_r.state = roc_pkg::ST_RUN;
            next_r.start = 1'b1;
          end
        end
        roc_pkg::ST_RUN:
        begin
          if (drop)
          begin
            next_r.start = 1'b0;
            if (inverse && r.mode <= roc_pkg::MODE_IEC_LI)
            begin
              next_r.state = roc_pkg::ST_HOLD;
              next_r.rcnt = 16'h0;
            end
            else
            begin
              next_r.state = roc_pkg::ST_IDLE;
              next_r.elapsed = 32'h0;
            end
          end
          else
          begin
            // Timer keeps counting at any level above pickup
            if (r.tick && r.elapsed != 32'hffffffff)
              next_r.elapsed = r.elapsed + 32'h1;
            if (r.elapsed >= need_ms)
            begin
              next_r.state = roc_pkg::ST_TRIP;
              next_r.trip = 1'b1;
            end
          end
        end
        roc_pkg::ST_TRIP:
        begin
          next_r.start = 1'b1;
          next_r.trip = 1'b1;
          if (drop)
          begin
            next_r.state = roc_pkg::ST_IDLE;
            next_r.start = 1'b0;
            next_r.trip = 1'b0;
            next_r.elapsed = 32'h0;
          end
        end
        roc_pkg::ST_HOLD:
        begin
          // Fixed reset delay keeps the accumulated time for a quick return
          if (above)
          begin
            next_r.state = roc_pkg::ST_RUN;
            next_r.start = 1'b1;
          end
          else if (r.rcnt >= r.rst_dly)
          begin
            next_r.state = roc_pkg::ST_IDLE;
            next_r.elapsed = 32'h0;
          end
          else if (r.tick)
            next_r.rcnt = r.rcnt + 16'h1;
        end
        default:
        begin
          next_r.state = roc_pkg::ST_IDLE;
        end
      endcase
    end

    // Decision stage
    next_r.gen_start = next_r.start & ~r.blocked;
    next_r.gen_trip = next_r.trip & ~r.blocked;

    // Register writes
    if (wr_hit)
    begin
      case (reg_addr_i)
        roc_pkg::ADDR_MODE:
        begin
          if (reg_wdata_i[3:0] <= roc_pkg::MODE_ANSI_LEI)
            next_r.mode = roc_pkg::roc_mode_t'(reg_wdata_i[3:0]);
          next_r.sens = reg_wdata_i[roc_pkg::MODE_SENS_BIT];
        end
        roc_pkg::ADDR_PICKUP:
        begin
          if (r.sens)
            next_r.pickup = 10'(clamp16(reg_wdata_i, roc_pkg::PICKUP_MIN_SENS,
              roc_pkg::PICKUP_MAX));
          else
            next_r.pickup = 10'(clamp16(reg_wdata_i, roc_pkg::PICKUP_MIN,
              roc_pkg::PICKUP_MAX));
        end
        roc_pkg::ADDR_MULT:
          next_r.mult = 11'(clamp16(reg_wdata_i, roc_pkg::MULT_MIN,
            roc_pkg::MULT_MAX));
        roc_pkg::ADDR_MIN_DLY:
          next_r.min_dly = clamp16(reg_wdata_i, roc_pkg::DLY_MIN,
            roc_pkg::DLY_MAX);
        roc_pkg::ADDR_DEF_DLY:
          next_r.def_dly = clamp16(reg_wdata_i, roc_pkg::DLY_MIN,
            roc_pkg::DLY_MAX);
        roc_pkg::ADDR_RST_DLY:
          next_r.rst_dly = clamp16(reg_wdata_i, roc_pkg::RST_DLY_MIN,
            roc_pkg::DLY_MAX);
        roc_pkg::ADDR_IRQ_MASK:
          next_r.irq_mask = reg_wdata_i[1:0];
        default:
        begin
        end
      endcase
    end

    // Register reads, data valid in the next cycle
    if (rd_hit)
    begin
      case (reg_addr_i)
        roc_pkg::ADDR_MODE:
          next_r.rdata = {27'h0, r.sens, r.mode};
        roc_pkg::ADDR_PICKUP:
          next_r.rdata = {22'h0, r.pickup};
        roc_pkg::ADDR_MULT:
          next_r.rdata = {21'h0, r.mult};
        roc_pkg::ADDR_MIN_DLY:
          next_r.rdata = {16'h0, r.min_dly};
        roc_pkg::ADDR_DEF_DLY:
          next_r.rdata = {16'h0, r.def_dly};
        roc_pkg::ADDR_RST_DLY:
          next_r.rdata = {16'h0, r.rst_dly};
        roc_pkg::ADDR_STATUS:
          next_r.rdata = {25'h0, r.state, r.blocked, r.gen_trip, r.gen_start,
            r.trip, r.start};
        roc_pkg::ADDR_IRQ_STAT:
        begin
          next_r.rdata = {30'h0, r.irq_stat};
          next_r.irq_stat = 2'b00;
        end
        roc_pkg::ADDR_IRQ_MASK:
          next_r.rdata = {30'h0, r.irq_mask};
        roc_pkg::ADDR_OP_TIME:
          next_r.rdata = need_ms;
        roc_pkg::ADDR_ELAPSED:
          next_r.rdata = r.elapsed;
        default:
          next_r.rdata = 32'h0;
      endcase
    end

    // Interrupt events; a new event wins over a clearing read
    events = 2'b00;
    events[roc_pkg::IRQ_START_BIT] = next_r.gen_start & ~r.gen_start;
    events[roc_pkg::IRQ_TRIP_BIT] = next_r.gen_trip & ~r.gen_trip;
    next_r.irq_stat = next_r.irq_stat | events;
  end

  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      r <= REGS_RST;
    else
      r <= next_r;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata_o = r.rdata;
  assign internal_start_flag_o = r.start;
  assign internal_trip_flag_o = r.trip;
  assign general_start_out_o = r.gen_start;
  assign general_trip_out_o = r.gen_trip;
  assign irq_o = |(r.irq_stat & r.irq_mask);

endmodule

// ===== verification/roc_front_model.sv
// Model of the measurement front end and the user blocking equation.
// Assumes bench commands change just after rising edges.
`timescale 1ns/10ps
module roc_front_model (
  input wire logic ref_clk_i,
  input wire logic [15:0] level_i,
  input wire logic slow_i,
  input wire logic block_i,
  output logic [15:0] rms_o = 16'h0,
  output logic valid_o = 1'b0,
  output logic block_o = 1'b0
);
  logic [1:0] phase = 2'h0;
  // Slow mode strobes one cycle in four; between strobes the data is scrambled
  always @(posedge ref_clk_i)
  begin
    phase <= phase + 2'h1;
    valid_o <= !slow_i || phase == 2'h3;
    rms_o <= (!slow_i || phase == 2'h3) ? level_i : ~level_i;
    block_o <= block_i;
  end
endmodule

// ===== verification/roc_trip_checker.sv
// Concurrent checks on the residual overcurrent trip block.
// Sees only the top module ports and is bound into every roc_trip_top.
`timescale 1ns/10ps
module roc_trip_checker #(
  parameter int unsigned TICK_CYCLES = 4
) (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic [5:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic function_block_in_i,
  input wire logic internal_start_flag_o,
  input wire logic internal_trip_flag_o,
  input wire logic general_start_out_o,
  input wire logic general_trip_out_o,
  input wire logic irq_o
);
  // Shortest definite delay, less one tick and pipeline slack
  localparam int unsigned MIN_RUN = 39 * TICK_CYCLES - 3;
  logic [3:0] mode;
  logic [1:0] mask;
  logic [31:0] run;

  // ----------------------------------------------------------------
  // Shadows of mode, mask and start duration
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      mode <= 4'h0;
      mask <= 2'h0;
      run <= 32'h0;
    end
    else
    begin
      if (reg_wr_i && reg_addr_i == roc_pkg::ADDR_MODE && reg_wdata_i[3:0] <= 4'hc)
        mode <= reg_wdata_i[3:0];
      if (reg_wr_i && reg_addr_i == roc_pkg::ADDR_IRQ_MASK)
        mask <= reg_wdata_i[1:0];
      run <= internal_start_flag_o ? run + 32'h1 : 32'h0;
    end
  end

  default clocking dc @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_block_held;
    function_block_in_i [*8];
  endsequence
  sequence s_mode_off;
    (mode == 4'h0) [*4];
  endsequence

  AST_GEN_START: assert property (general_start_out_o == internal_start_flag_o)
    else $error("general start differs from internal start");
  AST_GEN_TRIP: assert property (general_trip_out_o == internal_trip_flag_o)
    else $error("general trip differs from internal trip");
  AST_TRIP_START: assert property (internal_trip_flag_o |-> internal_start_flag_o)
    else $error("trip without start");
  AST_BLOCK: assert property (s_block_held |->
    !internal_start_flag_o && !internal_trip_flag_o)
    else $error("outputs active while blocked");
  AST_MODE_OFF: assert property (s_mode_off |-> !general_start_out_o && !general_trip_out_o)
    else $error("outputs active with mode off");
  AST_DEF_DELAY: assert property ($rose(internal_trip_flag_o) && mode == 4'h1 |->
    run >= MIN_RUN)
    else $error("definite trip too early");
  AST_RDATA_IDLE: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
    else $error("read data outside its cycle");
  AST_IRQ_MASKED: assert property (mask == 2'h0 && $past(mask) == 2'h0 |-> !irq_o)
    else $error("interrupt with all masked");
  AST_IRQ_RISE: assert property ($rose(general_trip_out_o) && mask[1] |-> ##[0:2] irq_o)
    else $error("no interrupt on trip");
endmodule

bind roc_trip_top roc_trip_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .ref_clk_i(ref_clk_i),
  .rstn_i(rstn_i),
  .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i),
  .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o),
  .function_block_in_i(function_block_in_i),
  .internal_start_flag_o(internal_start_flag_o),
  .internal_trip_flag_o(internal_trip_flag_o),
  .general_start_out_o(general_start_out_o),
  .general_trip_out_o(general_trip_out_o),
  .irq_o(irq_o)
);

// ===== verification/roc_trip_top_bench.sv
// Self-checking bench for the residual overcurrent trip block.
// Assumes the checker is bound in from its own file.
`timescale 1ns/10ps
module roc_trip_top_bench;
  localparam int unsigned TICK = 4;
  localparam logic [5:0] RA [0:8] = '{roc_pkg::ADDR_MODE, roc_pkg::ADDR_PICKUP,
    roc_pkg::ADDR_MULT, roc_pkg::ADDR_MIN_DLY, roc_pkg::ADDR_DEF_DLY, roc_pkg::ADDR_RST_DLY,
    roc_pkg::ADDR_IRQ_MASK, roc_pkg::ADDR_IRQ_STAT, 6'h2c};
  localparam logic [31:0] RV [0:8] = '{32'h0, 32'h32, 32'h64, 32'h64, 32'h64, 32'h64,
    32'h0, 32'h0, 32'h0};
  localparam logic [5:0] CA [0:8] = '{roc_pkg::ADDR_PICKUP, roc_pkg::ADDR_PICKUP,
    roc_pkg::ADDR_MULT, roc_pkg::ADDR_MULT, roc_pkg::ADDR_MIN_DLY, roc_pkg::ADDR_DEF_DLY,
    roc_pkg::ADDR_DEF_DLY, roc_pkg::ADDR_RST_DLY, roc_pkg::ADDR_RST_DLY};
  localparam logic [31:0] CW [0:8] = '{32'h2, 32'h7d0, 32'h1, 32'h7d0, 32'ha, 32'h0,
    32'hffff, 32'ha, 32'hffff};
  localparam logic [31:0] CE [0:8] = '{32'ha, 32'h3e8, 32'h5, 32'h5dc, 32'h28, 32'h28,
    32'hea60, 32'h3c, 32'hea60};
  logic ref_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [5:0] reg_addr_i = 6'h0;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [15:0] level = 16'h0;
  logic slow = 1'b0, block = 1'b0;
  logic [31:0] reg_rdata_o;
  logic [15:0] rms;
  logic valid, blk;
  wire [4:0] obs;
  int errors = 0, check_count = 0;
  int n;

  always #5 ref_clk_i = ~ref_clk_i;

  roc_front_model u_front (.ref_clk_i(ref_clk_i), .level_i(level), .slow_i(slow),
    .block_i(block), .rms_o(rms), .valid_o(valid), .block_o(blk));

  roc_trip_top #(.TICK_CYCLES(TICK)) u_dut (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o),
    .residual_fundamental_rms_i(rms),
    .rms_valid_i(valid),
    .function_block_in_i(blk),
    .internal_start_flag_o(obs[0]),
    .internal_trip_flag_o(obs[1]),
    .general_start_out_o(obs[2]),
    .general_trip_out_o(obs[3]),
    .irq_o(obs[4])
  );

  // ----------------------------------------------------------------
  // Bus cycles and comparisons
  // ----------------------------------------------------------------
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rdc(input logic [5:0] a, input logic [31:0] lo, input logic [31:0] hi);
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    check_count++;
    if (^reg_rdata_o === 1'bx || reg_rdata_o < lo || reg_rdata_o > hi)
    begin
      errors++;
      $display("BAD reg %h expected %h..%h seen %h", a, lo, hi, reg_rdata_o);
    end
  endtask

  task automatic waitb(input int b, input logic v, input int lim, input string nm);
    n = 0;
    while (obs[b] !== v && n < lim)
    begin
      @(posedge ref_clk_i);
      #1;
      n++;
    end
    check_count++;
    if (obs[b] !== v)
    begin
      errors++;
      $display("BAD %s expected %b seen %b", nm, v, obs[b]);
    end
  endtask

  task automatic chk_n(input int lo, input int hi, input string nm);
    check_count++;
    if (n < lo || n > hi)
    begin
      errors++;
      $display("BAD %s expected %0d..%0d seen %0d", nm, lo, hi, n);
    end
  endtask

  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    repeat (40000) @(posedge ref_clk_i);
    errors++;
    end_of_test();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (16) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    for (int i = 0; i < 9; i++)
      rdc(RA[i], RV[i], RV[i]);
    for (int i = 0; i < 9; i++)
    begin
      wr(CA[i], CW[i]);
      rdc(CA[i], CE[i], CE[i]);
    end
    wr(roc_pkg::ADDR_MODE, 32'h10);
    wr(roc_pkg::ADDR_PICKUP, 32'h2);
    rdc(roc_pkg::ADDR_PICKUP, 32'h5, 32'h5);
    wr(roc_pkg::ADDR_MODE, 32'h1d);
    rdc(roc_pkg::ADDR_MODE, 32'h10, 32'h10);
    for (int m = 0; m < 13; m++)
    begin
      wr(roc_pkg::ADDR_MODE, 32'(m));
      rdc(roc_pkg::ADDR_MODE, 32'(m), 32'(m));
    end
    // Definite time with a drop-out before the trip
    wr(roc_pkg::ADDR_PICKUP, 32'h32);
    wr(roc_pkg::ADDR_DEF_DLY, 32'h28);
    wr(roc_pkg::ADDR_IRQ_MASK, 32'h3);
    wr(roc_pkg::ADDR_MODE, 32'h1);
    slow <= 1'b1;
    level <= 16'h3e8;
    waitb(0, 1'b1, 12, "start");
    waitb(2, 1'b1, 1, "general start");
    repeat (20 * TICK) @(posedge ref_clk_i);
    level <= 16'h0;
    waitb(0, 1'b0, 12, "start drop");
    waitb(1, 1'b0, 0, "trip after drop");
    level <= 16'h3e8;
    waitb(0, 1'b1, 12, "start again");
    waitb(1, 1'b1, 45 * TICK, "trip");
    chk_n(37 * TICK, 42 * TICK, "definite delay");
    waitb(3, 1'b1, 1, "general trip");
    waitb(4, 1'b1, 3, "irq");
    rdc(roc_pkg::ADDR_IRQ_STAT, 32'h3, 32'h3);
    rdc(roc_pkg::ADDR_IRQ_STAT, 32'h0, 32'h0);
    waitb(4, 1'b0, 3, "irq cleared");
    // Blocking, then mode off with current still high
    block <= 1'b1;
    waitb(1, 1'b0, 12, "trip blocked");
    waitb(0, 1'b0, 1, "start blocked");
    repeat (10) @(posedge ref_clk_i);
    block <= 1'b0;
    waitb(0, 1'b1, 16, "start unblocked");
    wr(roc_pkg::ADDR_MODE, 32'h0);
    waitb(0, 1'b0, 5, "start mode off");
    repeat (50) @(posedge ref_clk_i);
    waitb(2, 1'b0, 0, "general start off");
    // Inverse curve with capped ratio, minimum delay and near pickup
    slow <= 1'b0;
    level <= 16'h4e20;
    wr(roc_pkg::ADDR_MULT, 32'h64);
    wr(roc_pkg::ADDR_MODE, 32'h3);
    repeat (6) @(posedge ref_clk_i);
    rdc(roc_pkg::ADDR_OP_TIME, 32'h2c5, 32'h2c8);
    wr(roc_pkg::ADDR_MODE, 32'h0);
    wr(roc_pkg::ADDR_MULT, 32'h5);
    wr(roc_pkg::ADDR_MODE, 32'h3);
    waitb(0, 1'b1, 8, "inverse start");
    rdc(roc_pkg::ADDR_OP_TIME, 32'h28, 32'h28);
    waitb(1, 1'b1, 45 * TICK, "inverse trip");
    chk_n(35 * TICK, 42 * TICK, "minimum delay");
    wr(roc_pkg::ADDR_MODE, 32'h0);
    level <= 16'h230;
    wr(roc_pkg::ADDR_IRQ_MASK, 32'h0);
    wr(roc_pkg::ADDR_MODE, 32'h3);
    waitb(1, 1'b1, 6100 * TICK, "trip near pickup");
    chk_n(5300 * TICK, 6100 * TICK, "curve delay");
    waitb(4, 1'b0, 0, "irq masked");
    end_of_test();
  end
endmodule
